// ### ub_defs.svh
// offsets, field codes and reset values of the serial bit-rate block
// assumes a 32-bit AXI4-Lite register bus with 8-bit byte addresses
`ifndef UB_DEFS_SVH
`define UB_DEFS_SVH

`define UB_ADDR_W 8
`define UB_OFF_MODE 8'h00
`define UB_OFF_DIVISOR 8'h04
`define UB_OFF_STATUS 8'h08
`define UB_OFF_TXDATA 8'h0C
`define UB_OFF_RXDATA 8'h10
`define UB_OFF_RXTIMEOUT 8'h14
`define UB_OFF_GUARD 8'h18
`define UB_OFF_CONTROL 8'h1C

`define UB_MODE_RESET 16'h0430
`define UB_DIV_RESET 16'h0000

`define UB_CLK_MCK 2'h0
`define UB_CLK_DIV 2'h1
`define UB_CLK_EXT 2'h3

`define UB_PAR_EVEN 3'h0
`define UB_PAR_ODD 3'h1
`define UB_PAR_SPACE 3'h2
`define UB_PAR_MARK 3'h3
`define UB_PAR_NONE 3'h4
`define UB_PAR_MULTI 3'h6

`define UB_STOP_15 2'h1
`define UB_STOP_2 2'h2

`define UB_CH_ECHO 2'h1
`define UB_CH_LOCAL 2'h2
`define UB_CH_REMOTE 2'h3

`define UB_CHAR_BASE 4'h5
`define UB_CHAR_MAX 4'h9
`define UB_SPB_X16 5'h10
`define UB_SPB_X8 5'h08
`define UB_SPB_SYNC 5'h01

`define UB_TXD_ADDR_BIT 9
`define UB_CTRL_CLR_ERR 0
`define UB_CTRL_REARM 1

`define UB_RESP_OKAY 2'h0
`define UB_RESP_SLVERR 2'h2

`endif

// ### ub_pkg.sv
// types shared by the serial bit-rate block
// assumes ub_defs.svh for the numeric field codes
package ub_pkg;

  typedef struct packed {
    logic [1:0] chmode;
    logic handshake;
    logic [1:0] stop;
    logic [2:0] parity;
    logic msbf;
    logic [2:0] chrl;
    logic over;
    logic sync;
    logic [1:0] clock_source_select;
  } mode_s;

  typedef struct packed {
    logic cts;
    logic tx_empty;
    logic rx_addr;
    logic timeout;
    logic par_err;
    logic frame_err;
    logic overrun;
    logic tx_ready;
    logic rx_ready;
  } status_s;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_SHIFT = 3'b010,
    TX_GUARD = 3'b100
  } tx_state_e;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b01,
    RX_FRAME = 2'b10
  } rx_state_e;

endpackage

// ### rate_divider.sv
// reloading down-counter that turns source ticks into sampling ticks
// assumes i_src_tick is a one-cycle pulse on the common clock
`timescale 1ns/1ps
module rate_divider #(
  parameter int WIDTH = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_hold,
  input wire logic i_src_tick,
  input wire logic [WIDTH-1:0] i_divisor,
  output logic o_tick
);
  logic [WIDTH-1:0] count;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count <= '0;
      o_tick <= 1'b0;
    end else if (i_hold) begin
      // a tick in flight waits out the freeze, else it is lost on restart
      o_tick <= o_tick;
    end else begin
      o_tick <= 1'b0;
      if (i_src_tick) begin
        if (i_divisor == '0) begin
          count <= '0;
        end else if (count <= WIDTH'(1)) begin
          // nonzero divisor sampled only here, so a period is never cut short
          o_tick <= 1'b1;
          count <= i_divisor;
        end else begin
          count <= count - WIDTH'(1);
        end
      end
    end
  end
endmodule // rate_divider

// ### usart_baud_gen.sv
// serial transceiver: bit-rate generator, framing engine, AXI4-Lite registers
// assumes pins are synchronous to I_CLOCK; I_CORE_ENABLE is the gated-clock request
// Contract
// - clock source: master, master/fixed factor, pin
// - sixteen-bit programmable divisor in divider register
// - divisor zero stops all bit timing except sync external, which uses pin
// - divisor one passes source clock undivided
// - async: divisor gives sampling, then 16/8
// - oversampling bit picks 8 or 16 samples
// - async rate is source over 8(2-over)divisor
// - fastest async rate is master over eight
// - five to nine bits, either bit order
// - stop bits 1, 1.5, 2; sync 1 or 2
// - even, odd, mark, space or no parity
// - flag parity, framing and overrun errors
// - receive timeout, transmit guard, multidrop address bit
// - handshake drives request, honours clear-to-send
// - remote loopback, local loopback, automatic echo
// - absent modem pins have no effect
// - stopped clock resumes from frozen state
// - register writes accepted with clock stopped
// - sync bit clock is source over divisor
// - sync external code uses pin directly
//
// The placing of the registers and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "ub_defs.svh"
module usart_baud_gen #(
  parameter int DIV_FACTOR = 8,
  parameter bit HAS_MODEM_PINS = 1'b1
) (
  input wire logic I_CLOCK,
  input wire logic I_RESETN,
  input wire logic I_CORE_ENABLE,
  input wire logic I_RXD,
  input wire logic I_SCK,
  input wire logic I_CTS_N,
  output logic O_TXD,
  output logic O_RTS_N,
  input wire logic [`UB_ADDR_W-1:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [`UB_ADDR_W-1:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY
);
  import ub_pkg::*;

  localparam int PRE_W = (DIV_FACTOR > 2) ? $clog2(DIV_FACTOR) : 1;

  if (DIV_FACTOR < 2 || DIV_FACTOR > 256) begin : g_bad_div
    $error("DIV_FACTOR must lie in 2..256");
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) r[8*b +: 8] = wd[8*b +: 8];
    end
    return r;
  endfunction

  function automatic logic known(input logic [`UB_ADDR_W-1:0] a);
    return a == `UB_OFF_MODE || a == `UB_OFF_DIVISOR || a == `UB_OFF_STATUS ||
           a == `UB_OFF_TXDATA || a == `UB_OFF_RXDATA || a == `UB_OFF_RXTIMEOUT ||
           a == `UB_OFF_GUARD || a == `UB_OFF_CONTROL;
  endfunction

  function automatic logic [3:0] char_len(input mode_s m);
    return (m.chrl > 3'h4) ? `UB_CHAR_MAX : 4'(m.chrl) + `UB_CHAR_BASE;
  endfunction

  function automatic logic has_par(input mode_s m);
    return m.parity < `UB_PAR_NONE || m.parity == `UB_PAR_MULTI;
  endfunction

  // bit order reversal is its own inverse, so rx and tx share it
  function automatic logic [8:0] reorder(input logic [8:0] d, input logic [3:0] len,
                                         input logic msbf);
    logic [8:0] r;
    r = d;
    for (int i = 0; i < 9; i++) begin
      if (msbf && 4'(i) < len) r[i] = d[len - 4'(i) - 4'h1];
    end
    return r;
  endfunction

  function automatic logic par_bit(input logic [8:0] d, input logic [3:0] len,
                                   input logic [2:0] code, input logic adr);
    logic p;
    p = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < len) p = p ^ d[i];
    end
    case (code)
      `UB_PAR_EVEN: par_bit = p;
      `UB_PAR_ODD: par_bit = ~p;
      `UB_PAR_MARK: par_bit = 1'b1;
      `UB_PAR_MULTI: par_bit = adr;
      default: par_bit = 1'b0;
    endcase
  endfunction

  // start bit at index 0, line order upward, stop bits left at one
  function automatic logic [12:0] build_frame(input logic [8:0] d, input logic adr,
                                              input mode_s m);
    logic [12:0] f;
    logic [8:0] o;
    logic [3:0] len;
    f = '1;
    len = char_len(m);
    o = reorder(d, len, m.msbf);
    f[0] = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < len) f[i + 1] = o[i];
    end
    if (has_par(m)) f[len + 4'h1] = par_bit(d, len, m.parity, adr);
    return f;
  endfunction

  // half a stop bit is added as time, not as a bit; rx checks one stop
  function automatic logic [3:0] frame_len(input mode_s m, input logic rx);
    return 4'h1 + char_len(m) + {3'h0, has_par(m)} +
           ((!rx && m.stop == `UB_STOP_2) ? 4'h2 : 4'h1);
  endfunction

  logic rst_meta;
  logic rst_n;
  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  mode_s mode;
  logic [15:0] bit_rate_divisor;
  logic [15:0] rto;
  logic [7:0] guard;
  logic [8:0] thr;
  logic thr_addr;
  logic thr_full;
  logic [8:0] rhr;
  status_s stat;
  logic run;
  assign run = I_CORE_ENABLE;

  // register bus
  logic aw_held, w_held, next_aw_held, next_w_held, next_bvalid, next_rvalid;
  logic [`UB_ADDR_W-1:0] aw_addr;
  logic [31:0] w_data, rd_data;
  logic [3:0] w_strb;
  logic wr_do, ar_fire, rd_rhr, wr_tx, clr_err, rearm;
  always_comb begin
    wr_do = aw_held && w_held && !O_BVALID;
    ar_fire = I_ARVALID && O_ARREADY;
    rd_rhr = ar_fire && I_ARADDR == `UB_OFF_RXDATA;
    wr_tx = wr_do && aw_addr == `UB_OFF_TXDATA;
    clr_err = wr_do && aw_addr == `UB_OFF_CONTROL && w_strb[0] && w_data[`UB_CTRL_CLR_ERR];
    rearm = wr_do && aw_addr == `UB_OFF_CONTROL && w_strb[0] && w_data[`UB_CTRL_REARM];
    next_aw_held = (aw_held || (I_AWVALID && O_AWREADY)) && !wr_do;
    next_w_held = (w_held || (I_WVALID && O_WREADY)) && !wr_do;
    next_bvalid = wr_do || (O_BVALID && !I_BREADY);
    next_rvalid = ar_fire || (O_RVALID && !I_RREADY);
  end

  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      O_AWREADY <= 1'b0;
      O_WREADY <= 1'b0;
      O_BVALID <= 1'b0;
      O_BRESP <= `UB_RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      if (I_AWVALID && O_AWREADY) aw_addr <= I_AWADDR;
      if (I_WVALID && O_WREADY) begin
        w_data <= I_WDATA;
        w_strb <= I_WSTRB;
      end
      O_AWREADY <= !next_aw_held && !next_bvalid;
      O_WREADY <= !next_w_held && !next_bvalid;
      O_BVALID <= next_bvalid;
      if (wr_do) O_BRESP <= known(aw_addr) ? `UB_RESP_OKAY : `UB_RESP_SLVERR;
    end
  end

  // configuration is not gated by run, so it is taken with the core stopped
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      mode <= `UB_MODE_RESET;
      bit_rate_divisor <= `UB_DIV_RESET;
      rto <= '0;
      guard <= '0;
    end else if (wr_do) begin
      if (aw_addr == `UB_OFF_MODE) mode <= 16'(merge(32'(mode), w_data, w_strb));
      else if (aw_addr == `UB_OFF_DIVISOR)
        bit_rate_divisor <= 16'(merge(32'(bit_rate_divisor), w_data, w_strb));
      else if (aw_addr == `UB_OFF_RXTIMEOUT) rto <= 16'(merge(32'(rto), w_data, w_strb));
      else if (aw_addr == `UB_OFF_GUARD) guard <= 8'(merge(32'(guard), w_data, w_strb));
    end
  end

  always_comb begin
    if (I_ARADDR == `UB_OFF_MODE) rd_data = 32'(mode);
    else if (I_ARADDR == `UB_OFF_DIVISOR) rd_data = 32'(bit_rate_divisor);
    else if (I_ARADDR == `UB_OFF_STATUS) rd_data = 32'(stat);
    else if (I_ARADDR == `UB_OFF_TXDATA) rd_data = {22'h0, thr_addr, thr};
    else if (I_ARADDR == `UB_OFF_RXDATA) rd_data = {23'h0, rhr};
    else if (I_ARADDR == `UB_OFF_RXTIMEOUT) rd_data = 32'(rto);
    else if (I_ARADDR == `UB_OFF_GUARD) rd_data = 32'(guard);
    else rd_data = 32'h0;
  end

  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      O_ARREADY <= 1'b0;
      O_RVALID <= 1'b0;
      O_RDATA <= '0;
      O_RRESP <= `UB_RESP_OKAY;
    end else begin
      O_ARREADY <= !next_rvalid;
      O_RVALID <= next_rvalid;
      if (ar_fire) begin
        O_RDATA <= rd_data;
        O_RRESP <= known(I_ARADDR) ? `UB_RESP_OKAY : `UB_RESP_SLVERR;
      end
    end
  end

  // clock sources
  logic [PRE_W-1:0] pre_cnt;
  logic sck_q, sck_rise, pre_tick, src_tick, samp_tick, samp, bit_tick;
  logic [4:0] spb, ovs_cnt;
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt <= '0;
      sck_q <= 1'b0;
      ovs_cnt <= '0;
    end else if (run) begin
      pre_cnt <= pre_tick ? '0 : pre_cnt + PRE_W'(1);
      sck_q <= I_SCK;
      if (samp) ovs_cnt <= (ovs_cnt >= spb - 5'h1) ? 5'h0 : ovs_cnt + 5'h1;
    end
  end

  always_comb begin
    pre_tick = pre_cnt == PRE_W'(DIV_FACTOR - 1);
    sck_rise = run && I_SCK && !sck_q;
    case (mode.clock_source_select)
      `UB_CLK_MCK: src_tick = run;
      `UB_CLK_DIV: src_tick = run && pre_tick;
      `UB_CLK_EXT: src_tick = sck_rise;
      default: src_tick = 1'b0;
    endcase
    if (mode.sync) spb = `UB_SPB_SYNC;
    else spb = mode.over ? `UB_SPB_X8 : `UB_SPB_X16;
    if (mode.sync && mode.clock_source_select == `UB_CLK_EXT) samp = sck_rise;
    else samp = samp_tick;
    bit_tick = samp && ovs_cnt >= spb - 5'h1;
  end

  rate_divider #(.WIDTH(16)) u_div (
    .i_clk(I_CLOCK),
    .i_rst_n(rst_n),
    .i_hold(!run),
    .i_src_tick(src_tick),
    .i_divisor(bit_rate_divisor),
    .o_tick(samp_tick)
  );

  // transmitter
  tx_state_e tx_state;
  logic [12:0] tx_shift;
  logic [3:0] tx_left;
  logic [4:0] tx_scnt;
  logic [7:0] guard_cnt;
  logic tx_take, tx_line, cts_ok, stop15;
  assign cts_ok = !HAS_MODEM_PINS || !mode.handshake || !I_CTS_N;
  // start on a sampling tick, so the start bit is never cut short
  assign tx_take = run && tx_state == TX_IDLE && thr_full && cts_ok && samp;
  assign tx_line = (tx_state == TX_SHIFT) ? tx_shift[0] : 1'b1;
  assign stop15 = !mode.sync && mode.stop == `UB_STOP_15;

  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      thr <= '0;
      thr_addr <= 1'b0;
      thr_full <= 1'b0;
    end else begin
      if (wr_tx) begin
        thr <= w_data[8:0];
        thr_addr <= w_data[`UB_TXD_ADDR_BIT];
      end
      thr_full <= wr_tx || (thr_full && !tx_take);
    end
  end

  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      tx_state <= TX_IDLE;
      tx_shift <= '1;
      tx_left <= '0;
      tx_scnt <= '0;
      guard_cnt <= '0;
    end else if (run) begin
      case (tx_state)
        TX_IDLE: begin
          if (tx_take) begin
            tx_shift <= build_frame(thr, thr_addr, mode);
            tx_left <= frame_len(mode, 1'b0);
            tx_scnt <= spb - 5'h1;
            tx_state <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (samp && tx_scnt != 5'h0) begin
            tx_scnt <= tx_scnt - 5'h1;
          end else if (samp && tx_left == 4'h1) begin
            guard_cnt <= guard;
            tx_state <= (guard != 8'h0) ? TX_GUARD : TX_IDLE;
          end else if (samp) begin
            tx_shift <= {1'b1, tx_shift[12:1]};
            tx_left <= tx_left - 4'h1;
            tx_scnt <= (tx_left == 4'h2 && stop15) ? spb + (spb >> 1) - 5'h1 : spb - 5'h1;
          end
        end
        TX_GUARD: begin
          if (bit_tick && guard_cnt <= 8'h1) tx_state <= TX_IDLE;
          else if (bit_tick) guard_cnt <= guard_cnt - 8'h1;
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // receiver
  rx_state_e rx_state;
  logic [12:0] rx_frame;
  logic [3:0] rx_pos, rx_len;
  logic [4:0] rx_scnt;
  logic rx_in, rx_end, rx_pbit, rx_stop;
  logic [8:0] rx_raw, rx_data;
  always_comb begin
    if (mode.chmode == `UB_CH_LOCAL) rx_in = tx_line;
    else if (mode.chmode == `UB_CH_REMOTE) rx_in = 1'b1;
    else rx_in = I_RXD;
    rx_len = char_len(mode);
    rx_raw = 9'h0;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < rx_len) rx_raw[i] = rx_frame[i + 1];
    end
    rx_data = reorder(rx_raw, rx_len, mode.msbf);
    rx_pbit = rx_frame[rx_len + 4'h1];
    rx_stop = rx_frame[rx_len + 4'h1 + {3'h0, has_par(mode)}];
  end

  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      rx_state <= RX_IDLE;
      rx_frame <= '1;
      rx_pos <= '0;
      rx_scnt <= '0;
      rx_end <= 1'b0;
    end else begin
      rx_end <= 1'b0;
      if (run) begin
        case (rx_state)
          RX_IDLE: begin
            if (samp && !rx_in) begin
              rx_state <= RX_FRAME;
              rx_frame <= '1;
              rx_pos <= mode.sync ? 4'h1 : 4'h0;
              rx_scnt <= mode.sync ? 5'h0 : (spb >> 1) - 5'h1;
            end
          end
          RX_FRAME: begin
            if (samp && rx_scnt != 5'h0) begin
              rx_scnt <= rx_scnt - 5'h1;
            end else if (samp && rx_pos == 4'h0 && rx_in) begin
              rx_state <= RX_IDLE; // glitch, not a start bit
            end else if (samp) begin
              rx_frame[rx_pos] <= rx_in;
              rx_pos <= rx_pos + 4'h1;
              rx_scnt <= spb - 5'h1;
              if (rx_pos == frame_len(mode, 1'b1) - 4'h1) begin
                rx_state <= RX_IDLE;
                rx_end <= 1'b1;
              end
            end
          end
          default: rx_state <= RX_IDLE;
        endcase
      end
    end
  end

  // status: a set arriving with a clear wins
  logic [15:0] to_cnt;
  logic to_armed, to_hit;
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      to_cnt <= '0;
      to_armed <= 1'b0;
      to_hit <= 1'b0;
    end else begin
      to_hit <= 1'b0;
      if (rx_end || rearm) begin
        to_cnt <= '0;
        to_armed <= 1'b1;
      end else if (run && to_armed && rx_state == RX_IDLE && bit_tick && rto != 16'h0) begin
        to_cnt <= to_cnt + 16'h1;
        if (to_cnt == rto - 16'h1) begin
          to_armed <= 1'b0;
          to_hit <= 1'b1;
        end
      end
    end
  end

  status_s stat_q;
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      rhr <= '0;
      stat_q <= '0;
    end else begin
      if (rx_end) begin
        rhr <= rx_data;
        stat_q.rx_addr <= mode.parity == `UB_PAR_MULTI && rx_pbit;
      end
      stat_q.rx_ready <= rx_end || (stat_q.rx_ready && !rd_rhr);
      stat_q.overrun <= (rx_end && stat_q.rx_ready && !rd_rhr) ||
                        (stat_q.overrun && !clr_err);
      stat_q.frame_err <= (rx_end && !rx_stop) || (stat_q.frame_err && !clr_err);
      stat_q.par_err <= (rx_end && has_par(mode) && mode.parity != `UB_PAR_MULTI &&
                         rx_pbit != par_bit(rx_data, rx_len, mode.parity, 1'b0)) ||
                        (stat_q.par_err && !clr_err);
      stat_q.timeout <= to_hit || (stat_q.timeout && !clr_err);
    end
  end

  // holding-register and pin flags are live, not stored
  always_comb begin
    stat = stat_q;
    stat.tx_ready = !thr_full;
    stat.tx_empty = !thr_full && tx_state == TX_IDLE;
    stat.cts = HAS_MODEM_PINS && !I_CTS_N;
  end

  // pins; without handshake request-to-send stays asserted if HAS_MODEM_PINS is set, else it stays deasserted
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      O_TXD <= 1'b1;
      O_RTS_N <= 1'b1;
    end else begin
      if (mode.chmode == `UB_CH_ECHO || mode.chmode == `UB_CH_REMOTE) O_TXD <= I_RXD;
      else if (mode.chmode == `UB_CH_LOCAL) O_TXD <= 1'b1;
      else O_TXD <= tx_line;
      if (!HAS_MODEM_PINS) O_RTS_N <= 1'b1;
      else O_RTS_N <= mode.handshake && stat.rx_ready;
    end
  end
endmodule // usart_baud_gen

// ### usart_baud_gen_checker.sv
// bus handshake and line-freeze assertions for the bit-rate block
// assumes it is bound to usart_baud_gen and sees only its ports
`timescale 1ns/1ps
`include "ub_defs.svh"
module usart_baud_gen_checker (
  input wire logic I_CLOCK,
  input wire logic I_RESETN,
  input wire logic I_CORE_ENABLE,
  input wire logic I_RXD,
  input wire logic O_TXD,
  input wire logic [`UB_ADDR_W-1:0] I_AWADDR,
  input wire logic I_AWVALID,
  input wire logic O_AWREADY,
  input wire logic O_WREADY,
  input wire logic [1:0] O_BRESP,
  input wire logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [`UB_ADDR_W-1:0] I_ARADDR,
  input wire logic I_ARVALID,
  input wire logic O_ARREADY,
  input wire logic [31:0] O_RDATA,
  input wire logic [1:0] O_RRESP,
  input wire logic O_RVALID,
  input wire logic I_RREADY
);
  logic [`UB_ADDR_W-1:0] aw_q;
  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      aw_q <= '0;
    end else if (I_AWVALID && O_AWREADY) begin
      aw_q <= I_AWADDR;
    end
  end
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RESETN);
  chk_bvalid_hold: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
    else $error("write response dropped");
  chk_rvalid_hold: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
    else $error("read data dropped");
  chk_read_busy: assert property (O_RVALID |-> !O_ARREADY)
    else $error("read taken while answer pending");
  chk_write_busy: assert property (O_BVALID |-> !O_AWREADY && !O_WREADY)
    else $error("write taken while answer pending");
  chk_read_answer: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
    else $error("read answer late");
  chk_read_slverr: assert property (I_ARVALID && O_ARREADY && I_ARADDR > `UB_OFF_CONTROL
    |=> O_RRESP == `UB_RESP_SLVERR && O_RDATA == 32'h0)
    else $error("unmapped read not refused");
  chk_write_resp: assert property ($rose(O_BVALID) |-> O_BRESP ==
    ((aw_q > `UB_OFF_CONTROL || aw_q[1:0] != 2'h0) ? `UB_RESP_SLVERR : `UB_RESP_OKAY))
    else $error("wrong write response");
  // register stage lags one cycle, so frozen cycles are judged from the third on
  chk_txd_frozen: assert property (!I_CORE_ENABLE && !$past(I_CORE_ENABLE) &&
    !$past(I_CORE_ENABLE, 2) && $past(I_RXD) == $past(I_RXD, 2) |-> $stable(O_TXD))
    else $error("line moved while frozen");
endmodule // usart_baud_gen_checker
bind usart_baud_gen usart_baud_gen_checker chk_u (.I_CLOCK(I_CLOCK), .I_RESETN(I_RESETN),
  .I_CORE_ENABLE(I_CORE_ENABLE), .I_RXD(I_RXD), .O_TXD(O_TXD), .I_AWADDR(I_AWADDR),
  .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY), .O_WREADY(O_WREADY), .O_BRESP(O_BRESP),
  .O_BVALID(O_BVALID), .I_BREADY(I_BREADY), .I_ARADDR(I_ARADDR), .I_ARVALID(I_ARVALID),
  .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA), .O_RRESP(O_RRESP), .O_RVALID(O_RVALID),
  .I_RREADY(I_RREADY));

// ### serial_peer.sv
// remote serial device: sends characters and supplies the pin clock
// assumes a 16-cycle bit time for what it sends
`timescale 1ns/1ps
module serial_peer (
  input wire logic i_clk,
  input wire logic i_sck_on,
  output logic o_rxd,
  output logic o_sck
);
  initial begin
    o_rxd = 1'b1;
    o_sck = 1'b0;
  end
  // 10 MHz, phases of five master periods; still unless asked for
  always #50 if (i_sck_on) o_sck = !o_sck;
  task automatic send(input logic [7:0] b, input logic stp);
    logic [9:0] f;
    f = {stp, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      o_rxd <= f[i];
      repeat (16) @(posedge i_clk);
    end
    o_rxd <= 1'b1;
  endtask
endmodule // serial_peer

// ### usart_baud_gen_tb.sv
// self-checking bench for the bit-rate block
// assumes ub_defs.svh offsets and serial_peer on the line side
`timescale 1ns/1ps
`include "ub_defs.svh"
module usart_baud_gen_tb;
  localparam int DF = 8;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  localparam logic [31:0] MD [7] = '{32'h430, 32'h438, 32'h430, 32'h439, 32'h434, 32'h437,
    32'h43B};
  localparam logic [31:0] DV [7] = '{32'h1, 32'h1, 32'h3, 32'h1, 32'h5, 32'h9, 32'h1};
  localparam int EX [7] = '{16, 8, 48, 8 * DF, 5, 10, 80};
  typedef struct packed {
    logic [31:0] v;
    logic [31:0] m;
  } note_s;
  note_s q[$];
  note_s n;
  logic [31:0] tq[$];
  int lo = 0;
  int fail_count = 0;
  int check_count = 0;
  logic clk = 1'b0;
  logic rst_n, en, cts, sck_on, awv, wv, br, arv, rr, rxd, sck;
  logic [7:0] wa, ra, b;
  logic [31:0] wd;
  wire logic txd, rts, awr, wrd, bv, arr, rv;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire [3:0] rdy = {bv, rv, arr, awr & wrd};
  usart_baud_gen #(.DIV_FACTOR(DF), .HAS_MODEM_PINS(1'b1)) dut_u (.I_CLOCK(clk),
    .I_RESETN(rst_n), .I_CORE_ENABLE(en), .I_RXD(rxd), .I_SCK(sck), .I_CTS_N(cts),
    .O_TXD(txd), .O_RTS_N(rts), .I_AWADDR(wa), .I_AWVALID(awv), .O_AWREADY(awr),
    .I_WDATA(wd), .I_WSTRB(4'hF), .I_WVALID(wv), .O_WREADY(wrd), .O_BRESP(bresp),
    .O_BVALID(bv), .I_BREADY(br), .I_ARADDR(ra), .I_ARVALID(arv), .O_ARREADY(arr),
    .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rv), .I_RREADY(rr));
  serial_peer pr_u (.i_clk(clk), .i_sck_on(sck_on), .o_rxd(rxd), .o_sck(sck));
  initial forever #5 clk = !clk;
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  // ready is looked at a step after the edge, so it is what the next edge samples
  task automatic hs(input int w);
    logic k;
    do begin
      #1 k = rdy[w];
      @(posedge clk);
    end while (!k);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    hs(0);
    awv <= 1'b0;
    wv <= 1'b0;
    hs(3);
    br <= 1'b1;
    @(posedge clk);
    br <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
    q.push_back({v, m});
    ra <= a;
    arv <= 1'b1;
    hs(1);
    arv <= 1'b0;
    hs(2);
    rr <= 1'b1;
    @(posedge clk);
    rr <= 1'b0;
  endtask
  task automatic tx_done;
    wait (tq.size() == 0);
    // the slowest frame must end before the mode is rewritten
    repeat (800) @(posedge clk);
  endtask
  // 0xFF gives one low run per frame: the start bit
  always @(negedge clk) begin
    if (rv && rr) begin
      n = q.pop_front();
      chk("rdata", rdata & n.m, n.v);
    end
    if (txd === 1'b0) begin
      lo++;
    end else if (lo != 0) begin
      chk("start bit", lo, tq.pop_front());
      lo = 0;
    end
  end
  initial begin
    #1000000;
    fail_count++;
    end_of_test;
  end
  initial begin
    rst_n = 1'b0;
    en = 1'b1;
    cts = 1'b0;
    sck_on = 1'b0;
    {awv, wv, br, arv, rr} = 5'h0;
    {wa, ra, wd} = '0;
    void'($urandom(32'hE71D));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(`UB_OFF_MODE, {16'h0, `UB_MODE_RESET}, ALL);
    rd(`UB_OFF_DIVISOR, {16'h0, `UB_DIV_RESET}, ALL);
    rd(8'h40, 32'h0, ALL);
    chk("rts", rts, 1'b0);
    $display("test registers done");
    for (int i = 0; i < 7; i++) begin
      sck_on <= (i > 4);
      wr(`UB_OFF_MODE, MD[i]);
      wr(`UB_OFF_DIVISOR, DV[i]);
      tq.push_back(EX[i]);
      wr(`UB_OFF_TXDATA, 32'hFF);
      tx_done();
    end
    sck_on <= 1'b0;
    $display("test rates done");
    for (int k = 0; k < 2; k++) begin
      wr(`UB_OFF_MODE, k ? 32'h2430 : 32'h430);
      wr(`UB_OFF_DIVISOR, k);
      cts <= k[0];
      wr(`UB_OFF_TXDATA, 32'hFF);
      repeat (100) @(posedge clk);
      chk("idle line", txd, 1'b1);
      tq.push_back(16);
      cts <= 1'b0;
      wr(`UB_OFF_DIVISOR, 32'h1);
      tx_done();
    end
    $display("test stall done");
    tq.push_back(36);
    wr(`UB_OFF_TXDATA, 32'hFF);
    wait (txd === 1'b0);
    repeat (4) @(posedge clk);
    en <= 1'b0;
    repeat (20) @(posedge clk);
    en <= 1'b1;
    tx_done();
    $display("test freeze done");
    b = 8'($urandom);
    pr_u.send(b, 1'b1);
    repeat (40) @(posedge clk);
    chk("rts busy", rts, 1'b1);
    rd(`UB_OFF_RXDATA, {24'h0, b}, 32'hFF);
    rd(`UB_OFF_STATUS, 32'h0, 32'h1);
    pr_u.send(b, 1'b0);
    repeat (40) @(posedge clk);
    rd(`UB_OFF_STATUS, 32'h8, 32'h8);
    wr(`UB_OFF_CONTROL, 32'h1);
    rd(`UB_OFF_STATUS, 32'h0, 32'h8);
    $display("test receive done");
    en <= 1'b0;
    wr(`UB_OFF_DIVISOR, ALL);
    rd(`UB_OFF_DIVISOR, 32'hFFFF, ALL);
    en <= 1'b1;
    repeat (4) @(posedge clk);
    $display("test frozen config done");
    end_of_test();
  end
endmodule // usart_baud_gen_tb
